/* cmp_ctrl_pkg.sv */
// package: constants, fields and carriers of the comparator control block
package cmp_ctrl_pkg;

  // ==========================================================
  // bus geometry and register byte offsets
  localparam int          ADDR_W       = 6;
  localparam logic [5:0]  OFS_CTRL     = 6'h00;
  localparam logic [5:0]  OFS_FLAGS2   = 6'h04;
  localparam logic [5:0]  OFS_ENABLES2 = 6'h08;
  localparam logic [5:0]  OFS_INTCTL   = 6'h0C;
  localparam logic [5:0]  OFS_DIR      = 6'h10;
  localparam logic [5:0]  OFS_CONV1    = 6'h14;
  localparam logic [5:0]  OFS_PORT     = 6'h18;
  localparam logic [5:0]  OFS_LATCH    = 6'h1C;
  localparam logic [5:0]  OFS_IRQ_STAT = 6'h20;
  localparam logic [5:0]  OFS_IRQ_MASK = 6'h24;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ==========================================================
  // field positions
  localparam int          FLAG_BIT     = 6;
  localparam int          CMP_EN_BIT    = 6;
  localparam int          PERIPH_EN_BIT = 6;
  localparam int          GLOBAL_EN_BIT = 7;
  localparam int          IRQ_CHANGE   = 0;
  localparam int          IRQ_SOFT     = 1;

  // ==========================================================
  // modes and reset values
  localparam logic [2:0]  MODE_FOUR_TWO = 3'h6;
  localparam logic [2:0]  MODE_OFF      = 3'h7;
  localparam logic [2:0]  MODE_PIN_OUT  = 3'h3;
  localparam logic [7:0]  CTRL_RST      = 8'h07;
  localparam logic [7:0]  DIR_RST       = 8'hFF;
  localparam logic [3:0]  ACFG_RST      = 4'hF;
  localparam logic [7:0]  LATCH_RST     = 8'h00;
  localparam logic [1:0]  IRQ_RST       = 2'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [1:0] result;
    logic [1:0] invert;
    logic       input_switch;
    logic [2:0] cmp_mode_sel;
  } comparator_control_t;

  typedef struct packed {
    logic       cmp_on;
    logic       ref_to_pos;
    logic       input_switch;
    logic [2:0] cmp_mode_sel;
  } cmp_route_t;

endpackage

/* dual_comparator_control.sv */
// dual comparator control: registers, mismatch flag, pin routing
//
// The AXI4-Lite register port and the address map are this design's own decisions.
module dual_comparator_control (
  // clock and reset
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_rst,
  // axi4-lite write address and data
  input  wire logic                           i_awvalid,
  output logic                                o_awready,
  input  wire logic [cmp_ctrl_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                           i_wvalid,
  output logic                                o_wready,
  input  wire logic [31:0]                    i_wdata,
  input  wire logic [3:0]                     i_wstrb,
  // axi4-lite write response
  output logic                                o_bvalid,
  input  wire logic                           i_bready,
  output logic [1:0]                          o_bresp,
  // axi4-lite read
  input  wire logic                           i_arvalid,
  output logic                                o_arready,
  input  wire logic [cmp_ctrl_pkg::ADDR_W-1:0] i_araddr,
  output logic                                o_rvalid,
  input  wire logic                           i_rready,
  output logic [31:0]                         o_rdata,
  output logic [1:0]                          o_rresp,
  // analog front end
  input  wire logic [1:0]                     i_cmp_above,
  output cmp_ctrl_pkg::cmp_route_t            o_route,
  // port a pins
  input  wire logic [7:0]                     i_pa_in,
  output logic [7:0]                          o_pa_out,
  output logic [7:0]                          o_pa_oe_n,
  output logic [3:0]                          o_pa_analog,
  // sleep and interrupts
  input  wire logic                           i_sleep,
  output logic                                o_wake,
  output logic                                o_cmp_irq_req,
  output logic                                o_irq
);
  import cmp_ctrl_pkg::*;

  // ==========================================================
  // state
  comparator_control_t ctrl_reg;
  logic [7:0]          dir_reg;
  logic [3:0]          acfg_reg;
  logic [7:0]          latch_reg;
  logic                flag_reg;
  logic                cmp_en_reg;
  logic                periph_en_reg;
  logic                global_en_reg;
  logic [1:0]          irq_stat_reg;
  logic [1:0]          irq_mask_reg;
  logic [1:0]          copy_reg;
  logic [1:0]          cmp_s1_reg;
  logic [1:0]          cmp_s2_reg;
  logic [1:0]          cmp_s3_reg;
  logic [1:0]          cmp_stable_reg;
  logic [7:0]          pa_s1_reg;
  logic [7:0]          pa_s2_reg;
  logic [7:0]          pa_s3_reg;
  logic [7:0]          pa_stable_reg;
  logic                aw_hold_reg;
  logic                w_hold_reg;
  logic [ADDR_W-1:0]   aw_addr_reg;
  logic [7:0]          w_data_reg;
  logic                w_lane0_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                rvalid_reg;
  logic [31:0]         rdata_reg;
  logic [1:0]          rresp_reg;

  // ==========================================================
  // bus handshakes and decode
  wire aw_fire = i_awvalid && o_awready;
  wire w_fire  = i_wvalid && o_wready;
  wire ar_fire = i_arvalid && o_arready;
  wire wr_go   = aw_hold_reg && w_hold_reg && !bvalid_reg;

  assign o_awready = !aw_hold_reg && !bvalid_reg;
  assign o_wready  = !w_hold_reg && !bvalid_reg;
  assign o_arready = !rvalid_reg;
  assign o_bvalid  = bvalid_reg;
  assign o_bresp   = bresp_reg;
  assign o_rvalid  = rvalid_reg;
  assign o_rdata   = rdata_reg;
  assign o_rresp   = rresp_reg;

  wire wr_en      = wr_go && w_lane0_reg;
  wire wr_ctrl    = wr_en && (aw_addr_reg == OFS_CTRL);
  wire wr_flags   = wr_en && (aw_addr_reg == OFS_FLAGS2);
  wire wr_enables = wr_en && (aw_addr_reg == OFS_ENABLES2);
  wire wr_intctl  = wr_en && (aw_addr_reg == OFS_INTCTL);
  wire wr_dir     = wr_en && (aw_addr_reg == OFS_DIR);
  wire wr_conv    = wr_en && (aw_addr_reg == OFS_CONV1);
  wire wr_latch   = wr_en && (aw_addr_reg == OFS_LATCH);
  wire wr_stat    = wr_en && (aw_addr_reg == OFS_IRQ_STAT);
  wire wr_mask    = wr_en && (aw_addr_reg == OFS_IRQ_MASK);

  wire wr_mapped = (aw_addr_reg == OFS_CTRL)     ||
                   (aw_addr_reg == OFS_FLAGS2)   ||
                   (aw_addr_reg == OFS_ENABLES2) ||
                   (aw_addr_reg == OFS_INTCTL)   ||
                   (aw_addr_reg == OFS_DIR)      ||
                   (aw_addr_reg == OFS_CONV1)    ||
                   (aw_addr_reg == OFS_PORT)     ||
                   (aw_addr_reg == OFS_LATCH)    ||
                   (aw_addr_reg == OFS_IRQ_STAT) ||
                   (aw_addr_reg == OFS_IRQ_MASK);

  wire ctrl_access = (wr_go && (aw_addr_reg == OFS_CTRL)) ||
                     (ar_fire && (i_araddr == OFS_CTRL));

  // ==========================================================
  // comparator outputs
  // mode off
  wire       cmp_on = (ctrl_reg.cmp_mode_sel != MODE_OFF);
  wire [1:0] cmp_live = cmp_on ? (cmp_stable_reg ^ ctrl_reg.invert) : 2'h0;
  wire [1:0] cmp_raw  = cmp_on ? (i_cmp_above ^ ctrl_reg.invert) : 2'h0;

  wire mismatch = (cmp_live != copy_reg);
  wire flag_set = mismatch && !ctrl_access;
  wire new_evt  = flag_set && !flag_reg;
  wire soft_evt = wr_flags && w_data_reg[FLAG_BIT] && !flag_reg;

  // mode field and input switch bit drive the analog mux
  assign o_route.cmp_on       = cmp_on;
  assign o_route.ref_to_pos   = (ctrl_reg.cmp_mode_sel == MODE_FOUR_TWO);
  assign o_route.input_switch = ctrl_reg.input_switch;
  assign o_route.cmp_mode_sel = ctrl_reg.cmp_mode_sel;

  // ==========================================================
  // pins
  // unclocked path to pins 4 and 5
  wire       pin_cmp = (ctrl_reg.cmp_mode_sel == MODE_PIN_OUT);
  wire [1:0] pin45   = pin_cmp ? cmp_raw : latch_reg[5:4];

  assign o_pa_out = {latch_reg[7:6], pin45, latch_reg[3:0]};
  // direction bit is the active-low drive enable (1 = input)
  assign o_pa_oe_n   = dir_reg;
  assign o_pa_analog = acfg_reg;
  wire [7:0] port_rd = pa_stable_reg & ~{4'h0, acfg_reg};

  // ==========================================================
  // interrupt outputs
  // three enables gate the request
  assign o_cmp_irq_req = flag_reg && cmp_en_reg &&
                         periph_en_reg && global_en_reg;
  assign o_wake = i_sleep && flag_reg && cmp_en_reg;
  assign o_irq  = |(irq_stat_reg & irq_mask_reg);

  // ==========================================================
  // read mux
  logic [7:0] rd_byte;
  wire  rd_ok = (i_araddr == OFS_CTRL)     ||
                (i_araddr == OFS_FLAGS2)   ||
                (i_araddr == OFS_ENABLES2) ||
                (i_araddr == OFS_INTCTL)   ||
                (i_araddr == OFS_DIR)      ||
                (i_araddr == OFS_CONV1)    ||
                (i_araddr == OFS_PORT)     ||
                (i_araddr == OFS_LATCH)    ||
                (i_araddr == OFS_IRQ_STAT) ||
                (i_araddr == OFS_IRQ_MASK);

  always_comb begin
    rd_byte = 8'h00;
    unique case (i_araddr)
      OFS_CTRL:     rd_byte = {cmp_live, ctrl_reg.invert,
                               ctrl_reg.input_switch, ctrl_reg.cmp_mode_sel};
      OFS_FLAGS2:   rd_byte[FLAG_BIT] = flag_reg;
      OFS_ENABLES2: rd_byte[CMP_EN_BIT] = cmp_en_reg;
      OFS_INTCTL:   rd_byte = {global_en_reg, periph_en_reg, 6'h00};
      OFS_DIR:      rd_byte = dir_reg;
      OFS_CONV1:    rd_byte = {4'h0, acfg_reg};
      OFS_PORT:     rd_byte = port_rd;
      OFS_LATCH:    rd_byte = latch_reg;
      OFS_IRQ_STAT: rd_byte = {6'h00, irq_stat_reg};
      OFS_IRQ_MASK: rd_byte = {6'h00, irq_mask_reg};
      default:      rd_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // bus slave
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= 8'h00;
      w_lane0_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      if (w_fire) begin
        w_hold_reg  <= 1'b1;
        w_data_reg  <= i_wdata[7:0];
        w_lane0_reg <= i_wstrb[0];
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && i_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h0, rd_byte};
      rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && i_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // input synchronisers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cmp_s1_reg     <= 2'h0;
      cmp_s2_reg     <= 2'h0;
      cmp_s3_reg     <= 2'h0;
      cmp_stable_reg <= 2'h0;
      pa_s1_reg      <= 8'h00;
      pa_s2_reg      <= 8'h00;
      pa_s3_reg      <= 8'h00;
      pa_stable_reg  <= 8'h00;
    end else begin
      cmp_s1_reg <= i_cmp_above;
      cmp_s2_reg <= cmp_s1_reg;
      cmp_s3_reg <= cmp_s2_reg;
      pa_s1_reg  <= i_pa_in;
      pa_s2_reg  <= pa_s1_reg;
      pa_s3_reg  <= pa_s2_reg;
      if (cmp_s2_reg == cmp_s3_reg) begin
        cmp_stable_reg <= cmp_s3_reg;
      end
      if (pa_s2_reg == pa_s3_reg) begin
        pa_stable_reg <= pa_s3_reg;
      end
    end
  end

  // ==========================================================
  // control and configuration registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl_reg  <= CTRL_RST;
      dir_reg   <= DIR_RST;
      acfg_reg      <= ACFG_RST;
      latch_reg     <= LATCH_RST;
      cmp_en_reg    <= 1'b0;
      periph_en_reg <= 1'b0;
      global_en_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg.invert       <= w_data_reg[5:4];
        ctrl_reg.input_switch <= w_data_reg[3];
        ctrl_reg.cmp_mode_sel <= w_data_reg[2:0];
      end
      if (wr_enables) begin
        cmp_en_reg <= w_data_reg[CMP_EN_BIT];
      end
      if (wr_intctl) begin
        global_en_reg <= w_data_reg[GLOBAL_EN_BIT];
        periph_en_reg <= w_data_reg[PERIPH_EN_BIT];
      end
      if (wr_dir) begin
        dir_reg <= w_data_reg;
      end
      if (wr_conv) begin
        acfg_reg <= w_data_reg[3:0];
      end
      if (wr_latch) begin
        latch_reg <= w_data_reg;
      end
    end
  end

  // ==========================================================
  // mismatch flag and interrupt status
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      copy_reg     <= 2'h0;
      flag_reg     <= 1'b0;
      irq_stat_reg <= IRQ_RST;
      irq_mask_reg <= IRQ_RST;
    end else begin
      if (ctrl_access) begin
        copy_reg <= cmp_live;
      end
      // change sets flag; write zero clears only while no mismatch is pending, one sets
      if (wr_flags) begin
        flag_reg <= w_data_reg[FLAG_BIT] || flag_set;
      end else if (flag_set) begin
        flag_reg <= 1'b1;
      end
      if (wr_mask) begin
        irq_mask_reg <= w_data_reg[1:0];
      end
      irq_stat_reg[IRQ_CHANGE] <= new_evt ||
        (irq_stat_reg[IRQ_CHANGE] && !(wr_stat && w_data_reg[IRQ_CHANGE]));
      irq_stat_reg[IRQ_SOFT] <= soft_evt ||
        (irq_stat_reg[IRQ_SOFT] && !(wr_stat && w_data_reg[IRQ_SOFT]));
    end
  end

endmodule

/* cmp_ctrl_monitor.sv */
// checker: port-level properties of the comparator control block
module cmp_ctrl_monitor (
  // clock and reset
  input  wire logic                            i_sys_clk,
  input  wire logic                            i_rst,
  // register bus
  input  wire logic                            i_arvalid,
  input  wire logic                            o_arready,
  input  wire logic [cmp_ctrl_pkg::ADDR_W-1:0] i_araddr,
  input  wire logic                            o_rvalid,
  input  wire logic [31:0]                     o_rdata,
  input  wire logic                            o_bvalid,
  // comparators, pins and sleep
  input  wire logic [1:0]                      i_cmp_above,
  input  wire cmp_ctrl_pkg::cmp_route_t        o_route,
  input  wire logic [7:0]                      o_pa_out,
  input  wire logic [7:0]                      o_pa_oe_n,
  input  wire logic [3:0]                      o_pa_analog,
  input  wire logic                            i_sleep,
  input  wire logic                            o_wake,
  input  wire logic                            o_cmp_irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import cmp_ctrl_pkg::*;
  // ==========================================================
  // helpers
  logic       rd_port;
  logic [1:0] pin_rel;
  assign pin_rel = o_pa_out[5:4] ^ i_cmp_above;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst)
      rd_port <= 1'b0;
    else if (i_arvalid && o_arready)
      rd_port <= (i_araddr == OFS_PORT);
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // properties
  a_reset_state: assert property ($past(i_rst) |->
    o_route.cmp_mode_sel == MODE_OFF && o_pa_oe_n == DIR_RST
    && o_pa_analog == ACFG_RST) else $error("reset state wrong");
  a_ref_mode: assert property (o_route.ref_to_pos |->
    o_route.cmp_mode_sel == MODE_FOUR_TWO) else $error("ref outside mode");
  a_off_quiet: assert property (o_route.cmp_mode_sel == MODE_OFF |->
    !o_route.cmp_on && o_pa_out[5:4] == 2'h0) else $error("off mode live");
  a_pin_direct: assert property (o_route.cmp_mode_sel == MODE_PIN_OUT
    && $stable(o_route) && !$rose(o_bvalid) |-> $stable(pin_rel))
    else $error("pin not tracking comparator");
  a_cfg_by_write: assert property (!$stable({o_pa_oe_n, o_pa_analog,
    o_route}) |-> $rose(o_bvalid)) else $error("config moved alone");
  a_port_analog: assert property (o_rvalid && rd_port |->
    (o_rdata[3:0] & o_pa_analog) == 4'h0) else $error("analog pin read");
  a_wake_sleep: assert property (o_wake |-> i_sleep)
    else $error("wake outside sleep");
  a_req_wakes: assert property (o_cmp_irq_req && i_sleep |-> o_wake)
    else $error("enabled flag no wake");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  c_wake: cover property (o_wake);
  c_req: cover property (o_cmp_irq_req);
  c_pin: cover property (o_route.cmp_mode_sel == MODE_PIN_OUT && !o_pa_oe_n[4]);
endmodule

bind dual_comparator_control cmp_ctrl_monitor mon_u (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .i_araddr(i_araddr), .o_rvalid(o_rvalid),
  .o_rdata(o_rdata), .o_bvalid(o_bvalid), .i_cmp_above(i_cmp_above),
  .o_route(o_route), .o_pa_out(o_pa_out), .o_pa_oe_n(o_pa_oe_n),
  .o_pa_analog(o_pa_analog), .i_sleep(i_sleep), .o_wake(o_wake),
  .o_cmp_irq_req(o_cmp_irq_req));

/* cmp_far_side.sv */
// far side model: analog comparator front end and port a pin wires
module cmp_far_side (
  // analog levels and external pin drive
  input  wire logic [1:0][7:0]          i_pos,
  input  wire logic [1:0][7:0]          i_neg,
  input  wire logic [7:0]               i_ref,
  input  wire logic [7:0]               i_ext,
  // block side
  input  wire cmp_ctrl_pkg::cmp_route_t i_route,
  input  wire logic [7:0]               i_pa_out,
  input  wire logic [7:0]               i_pa_oe_n,
  output logic [1:0]                    o_cmp_above,
  output logic [7:0]                    o_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  import cmp_ctrl_pkg::*;
  // ==========================================================
  // comparators
  logic [1:0][7:0] pos_sel;
  assign pos_sel = i_route.ref_to_pos ? {i_ref, i_ref} : i_pos;
  assign o_cmp_above[0] = pos_sel[0] > i_neg[0];
  assign o_cmp_above[1] = pos_sel[1] > i_neg[1];
  // ==========================================================
  // pin wires
  // direction gates drive
  assign o_pins = (~i_pa_oe_n & i_pa_out) | (i_pa_oe_n & i_ext);
endmodule

/* testbench.sv */
// testbench: register-level tests of the comparator control block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import cmp_ctrl_pkg::*;
  // ==========================================================
  // signals
  logic            i_sys_clk, i_rst, i_awvalid, i_wvalid, i_bready;
  logic            i_arvalid, i_rready, i_sleep;
  logic            o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic            o_wake, o_cmp_irq_req, o_irq;
  logic [5:0]      i_awaddr, i_araddr;
  logic [31:0]     i_wdata, o_rdata;
  logic [3:0]      i_wstrb, o_pa_analog;
  logic [1:0]      o_bresp, o_rresp, i_cmp_above, ab;
  logic [7:0]      i_pa_in, o_pa_out, o_pa_oe_n, ext, vref;
  logic [1:0][7:0] pos, neg;
  logic [2:0]      m;
  cmp_route_t      o_route;
  int              n_mismatch, checked;
  // ==========================================================
  // design and far side
  dual_comparator_control dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .i_cmp_above(i_cmp_above),
    .o_route(o_route), .i_pa_in(i_pa_in), .o_pa_out(o_pa_out),
    .o_pa_oe_n(o_pa_oe_n), .o_pa_analog(o_pa_analog), .i_sleep(i_sleep),
    .o_wake(o_wake), .o_cmp_irq_req(o_cmp_irq_req), .o_irq(o_irq));
  cmp_far_side far_u (.i_pos(pos), .i_neg(neg), .i_ref(vref), .i_ext(ext),
    .i_route(o_route), .i_pa_out(o_pa_out), .i_pa_oe_n(o_pa_oe_n),
    .o_cmp_above(i_cmp_above), .o_pins(i_pa_in));
  // ==========================================================
  // tasks
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic       ta, tw, tb;
    logic [1:0] rsp;
    int         n;
    tb = 1'b0;
    n = 0;
    @(posedge i_sys_clk);
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_awaddr <= a;
    i_wdata <= {24'h0, d};
    i_bready <= 1'b1;
    while (!tb && n < 50) begin
      @(negedge i_sys_clk);
      ta = i_awvalid && o_awready;
      tw = i_wvalid && o_wready;
      tb = o_bvalid;
      rsp = o_bresp;
      n++;
      @(posedge i_sys_clk);
      if (ta)
        i_awvalid <= 1'b0;
      if (tw)
        i_wvalid <= 1'b0;
    end
    i_bready <= 1'b0;
    ck({31'h0, tb}, 32'h1);
    ck({30'h0, rsp}, {30'h0, er});
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e,
                    input logic [1:0] er = RESP_OKAY);
    logic        ta, tr;
    logic [31:0] d;
    logic [1:0]  rsp;
    int          n;
    tr = 1'b0;
    n = 0;
    @(posedge i_sys_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    while (!tr && n < 50) begin
      @(negedge i_sys_clk);
      ta = i_arvalid && o_arready;
      tr = o_rvalid;
      d = o_rdata;
      rsp = o_rresp;
      n++;
      @(posedge i_sys_clk);
      if (ta)
        i_arvalid <= 1'b0;
    end
    i_rready <= 1'b0;
    ck({30'h0, rsp}, {30'h0, er});
    if (er === RESP_OKAY)
      ck(d, e);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog and tests
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    n_mismatch++;
    end_sim;
  end
  initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_sleep} <= 6'h00;
    {i_awaddr, i_araddr, i_wdata} <= 44'h0;
    i_wstrb <= 4'hF;
    i_rst <= 1'b1;
    pos <= {8'd50, 8'd200};
    neg <= {8'd100, 8'd100};
    vref <= 8'd150;
    ext <= 8'hA5;
    repeat (6) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(OFS_CTRL, 32'h07);
    rd(OFS_DIR, 32'hFF);
    rd(OFS_CONV1, 32'h0F);
    rd(OFS_PORT, 32'hA0);
    wr(OFS_CTRL, 8'hC7);
    rd(OFS_CTRL, 32'h07);
    wr(OFS_CONV1, 8'h03);
    rd(OFS_PORT, 32'hA4);
    for (int k = 0; k < 8; k++) begin
      m = k[2:0];
      ab = (m == 3'h6) ? 2'b11 : 2'b01;
      ab = (m == 3'h7) ? 2'b00 : ab ^ m[1:0];
      wr(OFS_CTRL, {2'b11, m[1:0], m[0], m});
      repeat (8) @(posedge i_sys_clk);
      rd(OFS_CTRL, {24'h0, ab, m[1:0], m[0], m});
      ck({29'h0, o_route.cmp_mode_sel}, {29'h0, m});
      ck({31'h0, o_route.ref_to_pos}, {31'h0, m == 3'h6});
      ck({31'h0, o_route.input_switch}, {31'h0, m[0]});
      ck({31'h0, o_route.cmp_on}, {31'h0, m != 3'h7});
    end
    wr(OFS_DIR, 8'hCF);
    wr(OFS_CTRL, 8'h13);
    @(posedge i_sys_clk);
    pos[0] <= 8'd50;
    #1;
    ck({30'h0, o_pa_out[5:4]}, 32'h1);
    ck({30'h0, i_pa_in[5:4]}, 32'h1);
    wr(OFS_DIR, 8'hFF);
    ck({30'h0, i_pa_in[5:4]}, 32'h2);
    wr(OFS_CTRL, 8'h02);
    repeat (8) @(posedge i_sys_clk);
    rd(OFS_CTRL, 32'h02);
    wr(OFS_ENABLES2, 8'h40);
    wr(OFS_INTCTL, 8'hC0);
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_FLAGS2, 8'h00);
    wr(OFS_IRQ_STAT, 8'h03);
    rd(OFS_FLAGS2, 32'h00);
    @(posedge i_sys_clk);
    pos[0] <= 8'd200;
    repeat (8) @(posedge i_sys_clk);
    rd(OFS_FLAGS2, 32'h40);
    ck({31'h0, o_cmp_irq_req}, 32'h1);
    ck({31'h0, o_irq}, 32'h1);
    rd(OFS_IRQ_STAT, 32'h01);
    wr(OFS_IRQ_MASK, 8'h00);
    ck({31'h0, o_irq}, 32'h0);
    wr(OFS_IRQ_STAT, 8'h01);
    rd(OFS_IRQ_STAT, 32'h00);
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_FLAGS2, 8'h00);
    rd(OFS_FLAGS2, 32'h40);
    rd(OFS_CTRL, 32'h42);
    wr(OFS_FLAGS2, 8'h00);
    repeat (8) @(posedge i_sys_clk);
    rd(OFS_FLAGS2, 32'h00);
    @(posedge i_sys_clk);
    i_sleep <= 1'b1;
    pos[0] <= 8'd50;
    repeat (8) @(negedge i_sys_clk);
    ck({31'h0, o_wake}, 32'h1);
    rd(OFS_CTRL, 32'h02);
    i_sleep <= 1'b0;
    wr(OFS_INTCTL, 8'h40);
    ck({31'h0, o_cmp_irq_req}, 32'h0);
    rd(OFS_FLAGS2, 32'h40);
    wr(OFS_FLAGS2, 8'h00);
    wr(OFS_FLAGS2, 8'h40);
    rd(OFS_FLAGS2, 32'h40);
    rd(OFS_IRQ_STAT, 32'h03);
    wr(6'h3C, 8'h00, RESP_SLVERR);
    rd(6'h3C, 32'h0, RESP_SLVERR);
    end_sim;
  end
endmodule
